// ===== src/eeprom_defs.vh
// Constants for the 1 Kbit serial memory command port.
// Assumes one core clock at 40 MHz; host lines arrive already synchronous to it.
`ifndef EEPROM_DEFS_VH
`define EEPROM_DEFS_VH

`define OP_READ        4'h8
`define OP_PROG_LOW    3'h4
`define OP_UNLOCK      4'h3
`define OP_LOCK        4'h0
`define OP_CLEAR       4'h2
`define OP_FILL        4'h1
`define OPC_LAST       3'h3
`define ADDR_LAST_WORD 5'h05
`define ADDR_LAST_BYTE 5'h06
`define DATA_LAST_WORD 5'h0F
`define DATA_LAST_BYTE 5'h07
`define ERASED_WORD    16'hFFFF

`define JOB_PROG       2'h0
`define JOB_CLEAR      2'h1
`define JOB_FILL       2'h2
`define JOB_W          26
`define JOB_KIND_HI    25
`define JOB_KIND_LO    24
`define JOB_BYTE       23
`define JOB_ADDR_HI    22
`define JOB_ADDR_LO    16
`define JOB_DATA_HI    15
`define JOB_DATA_LO    0
`define FIFO_DEPTH     16

`define T_EW_US        10000
`define CORE_CLK_KHZ   40000
`define EW_CYCLES      (`T_EW_US * `CORE_CLK_KHZ / 1000)

`endif

// ===== src/serial_eeprom.v
// Serial command port of a 1 Kbit nonvolatile memory with self-timed programming.
// Assumes cs, sclk, serial_in and the strap are synchronous to core_clk and that
// sclk high and low phases each last at least two core clocks.
`timescale 1ns/10ps
`include "eeprom_defs.vh"

module job_fifo #(
  parameter WIDTH = 26,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] slot_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            do_push;
  wire            do_pop;

  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = slot_r[rd_ptr_r];
  assign do_push   = in_valid & in_ready;
  assign do_pop    = out_valid & out_ready;

  always @(posedge core_clk) begin
    if (do_push) begin
      slot_r[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_r <= count_r + 1'b1;
      end else if (do_pop && !do_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // job_fifo

module serial_eeprom #(
  parameter [19:0] EW_CYCLES = `EW_CYCLES
) (
  input  wire core_clk,
  input  wire rst,
  input  wire cs,
  input  wire sclk,
  input  wire serial_in,
  input  wire word_width_strap,
  output reg  serial_out,
  output reg  serial_out_oe,
  output reg  ready_busy,
  output reg  write_enabled
);
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_OPC  = 3'h1;
  localparam [2:0] S_ADDR = 3'h2;
  localparam [2:0] S_DATA = 3'h3;
  localparam [2:0] S_READ = 3'h4;
  localparam [2:0] S_DONE = 3'h5;

  reg  [1023:0]        mem_r;
  wire [1023:0]        mem_nxt;
  reg                  sclk_q_r;
  reg  [2:0]           st_r;
  reg  [4:0]           cnt_r;
  reg                  byte_mode_r;
  reg  [3:0]           op_r;
  reg  [5:0]           addr_r;
  reg  [14:0]          data_r;
  reg  [6:0]           job_addr_r;
  reg  [15:0]          rsh_r;
  reg                  push_r;
  reg  [`JOB_W-1:0]    job_r;
  reg                  eng_busy_r;
  reg  [19:0]          eng_cnt_r;
  reg  [`JOB_W-1:0]    eng_job_r;
  wire                 rise;
  wire [6:0]           addr_fin;
  wire [15:0]          data_fin;
  wire                 addr_zero;
  wire [4:0]           addr_last;
  wire [4:0]           data_last;
  wire [15:0]          rd_word;
  wire [15:0]          rd_load;
  wire                 fifo_in_ready;
  wire [`JOB_W-1:0]    fifo_out_data;
  wire                 fifo_out_valid;
  wire                 eng_take;
  wire                 eng_apply;
  wire [1:0]           eng_kind;
  wire                 eng_byte;
  wire [6:0]           eng_addr;
  wire [15:0]          eng_data;
  wire [15:0]          fill_word;

  assign rise      = sclk & ~sclk_q_r;
  assign addr_last = byte_mode_r ? `ADDR_LAST_BYTE : `ADDR_LAST_WORD;
  assign data_last = byte_mode_r ? `DATA_LAST_BYTE : `DATA_LAST_WORD;
  assign addr_fin  = byte_mode_r ? {addr_r[5:0], serial_in} : {1'b0, addr_r[4:0], serial_in};
  assign data_fin  = byte_mode_r ? {8'h00, data_r[6:0], serial_in} : {data_r[14:0], serial_in};
  assign addr_zero = (addr_fin == 7'h00);
  assign rd_word   = byte_mode_r ? mem_r[addr_fin[6:1]*16 +: 16] : mem_r[addr_fin[5:0]*16 +: 16];
  // Byte reads are left-aligned so the shifter always emits from bit 15
  assign rd_load   = !byte_mode_r ? rd_word :
                     addr_fin[0] ? {rd_word[15:8], 8'h00} : {rd_word[7:0], 8'h00};

  always @(posedge core_clk) begin
    if (rst) begin
      sclk_q_r      <= 1'b0;
      st_r          <= S_IDLE;
      cnt_r         <= 5'h00;
      byte_mode_r   <= 1'b0;
      op_r          <= 4'h0;
      addr_r        <= 6'h00;
      data_r        <= 15'h0000;
      job_addr_r    <= 7'h00;
      rsh_r         <= 16'h0000;
      push_r        <= 1'b0;
      job_r         <= {`JOB_W{1'b0}};
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
      write_enabled <= 1'b0;
    end else begin
      sclk_q_r <= sclk;
      push_r   <= 1'b0;
      if (!cs) begin
        // Aborts only the shifter; queued or running jobs carry on
        st_r          <= S_IDLE;
        serial_out_oe <= 1'b0;
        serial_out    <= 1'b0;
      end else if (rise) begin
        case (st_r)
          S_IDLE: begin
            if (serial_in) begin
              st_r        <= S_OPC;
              cnt_r       <= 5'h00;
              addr_r      <= 6'h00;
              data_r      <= 15'h0000;
              byte_mode_r <= ~word_width_strap;
            end
          end
          S_OPC: begin
            op_r <= {op_r[2:0], serial_in};
            if (cnt_r[2:0] == `OPC_LAST) begin
              st_r  <= S_ADDR;
              cnt_r <= 5'h00;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
          S_ADDR: begin
            addr_r <= {addr_r[4:0], serial_in};
            if (cnt_r == addr_last) begin
              cnt_r      <= 5'h00;
              job_addr_r <= addr_fin;
              st_r       <= S_DONE;
              if (op_r == `OP_READ) begin
                // Reads ignore the write latch
                st_r          <= S_READ;
                serial_out_oe <= 1'b1;
                serial_out    <= 1'b0;
                rsh_r         <= rd_load;
              end else if (op_r[2:0] == `OP_PROG_LOW) begin
                st_r <= S_DATA;
              end else if (op_r == `OP_FILL && addr_zero) begin
                st_r <= S_DATA;
              end else if (op_r == `OP_UNLOCK && addr_zero) begin
                write_enabled <= 1'b1;
              end else if (op_r == `OP_LOCK && addr_zero) begin
                write_enabled <= 1'b0;
              end else if (op_r == `OP_CLEAR && addr_zero) begin
                if (write_enabled && fifo_in_ready) begin
                  push_r <= 1'b1;
                  job_r  <= {`JOB_CLEAR, byte_mode_r, 7'h00, 16'h0000};
                end
              end
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
          S_DATA: begin
            data_r <= {data_r[13:0], serial_in};
            if (cnt_r == data_last) begin
              st_r <= S_DONE;
              if (write_enabled && fifo_in_ready) begin
                push_r <= 1'b1;
                job_r  <= {(op_r == `OP_FILL) ? `JOB_FILL : `JOB_PROG,
                           byte_mode_r, job_addr_r, data_fin};
              end
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
          S_READ: begin
            if (cnt_r == data_last + 5'h01) begin
              serial_out_oe <= 1'b0;
              serial_out    <= 1'b0;
              st_r          <= S_DONE;
            end else begin
              serial_out <= rsh_r[15];
              rsh_r      <= {rsh_r[14:0], 1'b0};
              cnt_r      <= cnt_r + 5'h01;
            end
          end
          S_DONE: begin
            st_r <= S_DONE;
          end
          default: begin
            st_r <= S_IDLE;
          end
        endcase
      end
    end
  end

  // Jobs wait here while a cycle runs; a full queue refuses new writes
  job_fifo #(
    .WIDTH (`JOB_W),
    .DEPTH (`FIFO_DEPTH),
    .AW    (4)
  ) u_jobs (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_data   (job_r),
    .in_valid  (push_r),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (eng_take)
  );

  assign eng_take  = ~eng_busy_r;
  assign eng_apply = eng_busy_r && (eng_cnt_r == EW_CYCLES - 20'h00001);
  assign eng_kind  = eng_job_r[`JOB_KIND_HI:`JOB_KIND_LO];
  assign eng_byte  = eng_job_r[`JOB_BYTE];
  assign eng_addr  = eng_job_r[`JOB_ADDR_HI:`JOB_ADDR_LO];
  assign eng_data  = eng_job_r[`JOB_DATA_HI:`JOB_DATA_LO];
  assign fill_word = eng_byte ? {eng_data[7:0], eng_data[7:0]} : eng_data;

  // Self-timed engine runs on core_clk alone, no serial clock needed
  always @(posedge core_clk) begin
    if (rst) begin
      eng_busy_r <= 1'b0;
      eng_cnt_r  <= 20'h00000;
      eng_job_r  <= {`JOB_W{1'b0}};
      ready_busy <= 1'b1;
    end else begin
      if (!eng_busy_r) begin
        if (fifo_out_valid) begin
          eng_busy_r <= 1'b1;
          eng_cnt_r  <= 20'h00000;
          eng_job_r  <= fifo_out_data;
        end
      end else if (eng_apply) begin
        eng_busy_r <= 1'b0;
      end else begin
        eng_cnt_r <= eng_cnt_r + 20'h00001;
      end
      ready_busy <= ~(push_r | fifo_out_valid | eng_busy_r);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_word
      localparam [5:0] IDX = g;
      wire [15:0] old  = mem_r[g*16 +: 16];
      wire        hit  = eng_byte ? (eng_addr[6:1] == IDX) : (eng_addr[5:0] == IDX);
      // Erase then store collapses to the new value
      wire [15:0] prog = !eng_byte ? eng_data :
                         eng_addr[0] ? {eng_data[7:0], old[7:0]} : {old[15:8], eng_data[7:0]};
      // Fill only clears bits, so the array must be erased first
      assign mem_nxt[g*16 +: 16] =
        !eng_apply                ? old :
        (eng_kind == `JOB_CLEAR)  ? `ERASED_WORD :
        (eng_kind == `JOB_FILL)   ? (old & fill_word) :
        hit                       ? prog : old;
    end
  endgenerate

  // Array contents are nonvolatile and deliberately not reset
  always @(posedge core_clk) begin
    mem_r <= mem_nxt;
  end
endmodule // serial_eeprom

// ===== tb/eeprom_checker.sv
// Pin-level assertions for the serial memory command port.
// Assumes sclk is seen on core_clk edges as the design samples it.
`timescale 1ns/10ps
module eeprom_checker (
  input logic core_clk,
  input logic rst,
  input logic cs,
  input logic sclk,
  input logic serial_out,
  input logic serial_out_oe,
  input logic ready_busy,
  input logic write_enabled
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_out_idle_low: assert property (!serial_out_oe |-> !serial_out)
    else $error("serial_out high while released");
  chk_oe_cs_drop: assert property (!cs ##1 !cs |-> !serial_out_oe)
    else $error("output still driven after chip select low");
  chk_oe_start: assert property ($rose(serial_out_oe) |->
    $past(cs) && $past(sclk) && !$past(sclk, 2) && !serial_out)
    else $error("read output start wrong");
  chk_out_on_rise: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
    |-> $past(sclk) && !$past(sclk, 2))
    else $error("read bit moved off a serial clock rise");
  chk_busy_hold: assert property ($fell(ready_busy) |-> !ready_busy [*8])
    else $error("busy released too early");
  chk_busy_bound: assert property ($fell(ready_busy) |-> ##[1:1000] ready_busy)
    else $error("programming never finished");
  chk_busy_locked: assert property ($fell(ready_busy) |-> $past(write_enabled, 3))
    else $error("programming started while locked");
  chk_latch_edge: assert property ($changed(write_enabled) |->
    $past(cs) && $past(sclk) && !$past(sclk, 2))
    else $error("write latch moved outside a command");
endmodule // eeprom_checker

// ===== tb/serial_eeprom_test.sv
// Self-checking bench for the serial memory command port.
// Assumes the design is built with a short programming time.
`timescale 1ns/10ps
module serial_eeprom_test;
  logic        core_clk, rst, strap, cs, sclk, serial_in;
  logic        serial_out, serial_out_oe, ready_busy, write_enabled;
  logic [16:0] rd;
  int          fail_count = 0;
  int          tests_run = 0;

  serial_eeprom #(.EW_CYCLES(20'd20)) uut (.core_clk(core_clk), .rst(rst), .cs(cs),
    .sclk(sclk), .serial_in(serial_in), .word_width_strap(strap), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .ready_busy(ready_busy), .write_enabled(write_enabled));
  serial_host host (.core_clk(core_clk), .cs(cs), .sclk(sclk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wcmd(input logic [3:0] op, input logic [5:0] a, input logic [15:0] d,
                      input bit dat);
    if (dat)
      host.xfer({5'h00, 1'b1, op, a, d}, 27, 0, rd);
    else
      host.xfer({21'h0, 1'b1, op, a}, 11, 0, rd);
  endtask

  task automatic rword(input logic [5:0] a, input logic [15:0] exp);
    host.xfer({21'h0, 1'b1, 4'h8, a}, 11, 16, rd);
    check(rd, {1'b0, exp});
  endtask

  // Poll with sclk parked; the cycle must finish on its own
  task automatic wait_ready;
    int n;
    n = 0;
    check(ready_busy, 1'b0);
    while (ready_busy !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    check(ready_busy, 1'b1);
  endtask

  initial begin
    rst = 1'b1;
    strap = 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check({ready_busy, write_enabled, serial_out_oe}, 3'h4);
    wcmd(4'h4, 6'h05, 16'h1234, 1);
    check(ready_busy, 1'b1);
    wcmd(4'h3, 6'h01, 16'h0000, 0);
    check(write_enabled, 1'b0);
    wcmd(4'h3, 6'h00, 16'h0000, 0);
    check(write_enabled, 1'b1);
    wcmd(4'h2, 6'h00, 16'h0000, 0);
    wait_ready;
    rword(6'h05, 16'hFFFF);
    wcmd(4'hC, 6'h05, 16'hA55A, 1);
    wait_ready;
    wcmd(4'h4, 6'h3F, 16'h8001, 1);
    wait_ready;
    rword(6'h05, 16'hA55A);
    rword(6'h3F, 16'h8001);
    strap <= 1'b0;
    host.xfer({20'h0, 1'b1, 4'h8, 7'h0B}, 12, 8, rd);
    check(rd, 17'h000A5);
    host.xfer({20'h0, 1'b1, 4'h8, 7'h0A}, 12, 8, rd);
    check(rd, 17'h0005A);
    host.xfer({12'h000, 1'b1, 4'h4, 7'h7E, 8'h3C}, 20, 0, rd);
    wait_ready;
    strap <= 1'b1;
    rword(6'h3F, 16'h803C);
    wcmd(4'h2, 6'h00, 16'h0000, 0);
    wait_ready;
    wcmd(4'h1, 6'h00, 16'h0F0F, 1);
    wait_ready;
    rword(6'h00, 16'h0F0F);
    rword(6'h3F, 16'h0F0F);
    host.xfer({12'h000, 1'b1, 4'h4, 6'h12, 9'h000}, 20, 0, rd);
    check(ready_busy, 1'b1);
    rword(6'h12, 16'h0F0F);
    host.xfer({21'h0, 1'b1, 4'h8, 6'h00}, 11, 0, rd);
    check(serial_out_oe, 1'b0);
    wcmd(4'h0, 6'h00, 16'h0000, 0);
    check(write_enabled, 1'b0);
    wcmd(4'h4, 6'h12, 16'h0000, 1);
    check(ready_busy, 1'b1);
    rword(6'h12, 16'h0F0F);
    finish_test;
  end

  // Whole sequence needs about 2300 clocks
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    finish_test;
  end
endmodule // serial_eeprom_test

bind serial_eeprom eeprom_checker chk (.core_clk(core_clk), .rst(rst), .cs(cs), .sclk(sclk),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .ready_busy(ready_busy),
  .write_enabled(write_enabled));

// ===== tb/serial_host.sv
// Host model: drives chip select, serial clock and data, samples read data.
// Assumes the caller waits for ready between programming commands.
`timescale 1ns/10ps
module serial_host (
  input  logic core_clk,
  output logic cs,
  output logic sclk,
  output logic serial_in,
  input  logic serial_out,
  input  logic serial_out_oe
);
  initial begin
    cs = 1'b0;
    sclk = 1'b0;
    serial_in = 1'b0;
  end

  // Two core clocks per phase, the shortest the device accepts
  task automatic pulse(input logic b);
    serial_in <= b;
    sclk      <= 1'b0;
    repeat (2) @(posedge core_clk);
    sclk <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // Bits sampled with serial_out_oe low show X so a missing output enable is caught
  task automatic xfer(input logic [31:0] bits, input int n, input int nrd,
                      output logic [16:0] rd);
    rd = '0;
    cs <= 1'b1;
    for (int i = n - 1; i >= 0; i--) pulse(bits[i]);
    if (nrd > 0) begin
      rd[nrd] = serial_out_oe ? serial_out : 1'bx;
      for (int i = nrd - 1; i >= 0; i--) begin
        pulse(~serial_in);
        rd[i] = serial_out_oe ? serial_out : 1'bx;
      end
      pulse(~serial_in);
    end
    cs        <= 1'b0;
    sclk      <= 1'b0;
    serial_in <= ~serial_in;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // serial_host
